// ==== logic/srq_bridge.sv ====
`timescale 1ns/1ps
`default_nettype none
module srq_bridge
(
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output var  logic [31:0]              prdata,
	output var  logic                     pready,
	output var  logic                     pslverr,
	input  wire logic                     cmd_valid,
	input  wire logic [2:0]               cmd_code,
	input  wire logic                     lbyte_valid,
	input  wire logic [7:0]               lbyte,
	input  wire logic                     tk_ready,
	output var  srq_bridge_pkg::talk_t    tk,
	output var  logic                     srq,
	output var  srq_bridge_pkg::dw_cmd_t  dw_cmd,
	output var  logic                     dw_busy,
	output var  logic                     dw_c,
	output var  logic                     dw_z,
	output var  logic                     dw_i,
	input  wire logic [23:0]              dw_r,
	input  wire logic                     dw_q,
	input  wire logic                     dw_x,
	input  wire logic [22:0]              lam
);
	// ==========================================================
	// state
	typedef struct packed {
		srq_bridge_pkg::mode_t   mode;
		srq_bridge_pkg::phase_t  ph;
		srq_bridge_pkg::bmode_t  bm;
		srq_bridge_pkg::dw_cmd_t cmd;
		srq_bridge_pkg::talk_t   tk;
		logic                    first;
		logic [2:0]              seq;
		logic [2:0]              en;
		logic                    inh;
		logic                    pc;
		logic                    pz;
		logic [1:0]              nb;
		logic [23:0]             rd;
		logic                    q;
		logic                    x;
		logic                    srq;
		logic [10:0]             cnt;
		logic [2:0]              bidx;
		logic                    last;
		logic                    busy;
		logic                    c;
		logic                    z;
		logic                    pready;
		logic                    pslverr;
		logic [31:0]             prdata;
	} st_t;

	st_t         s;
	st_t         next_s;
	logic [23:0] lam24;
	logic        soft_clr;
	logic        do_clr;
	logic        lam_ev;
	logic        cyc_end;
	logic        take;
	logic        setup_hit;
	logic [7:0]  out_b;
	logic        out_e;
	logic        out_l;
	logic [7:0]  lam_b [4];

	assign lam24    = {1'b0, lam};
	assign soft_clr = psel && penable && pwrite && s.pready
		&& paddr == srq_bridge_pkg::OFS_CTRL && pwdata[0];
	assign do_clr   = soft_clr || (cmd_valid && cmd_code == srq_bridge_pkg::G_IFC);
	assign lam_ev   = s.en[0] && |lam;
	assign cyc_end  = s.busy && s.cnt == 11'h000;
	assign take     = s.tk.valid && tk_ready;
	assign setup_hit = lbyte_valid && s.mode == srq_bridge_pkg::M_LISTEN && s.first
		&& (lbyte & srq_bridge_pkg::GRP_MASK) == srq_bridge_pkg::SRQ_BASE;

	// ==========================================================
	// lam bytes
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_lam
			assign lam_b[gi] = {2'b00, lam24[6*gi +: 6]};
		end
	endgenerate

	// ==========================================================
	// talker byte select
	always_comb
	begin
		out_b = 8'h00;
		out_e = 1'b0;
		out_l = 1'b0;
		if (s.mode == srq_bridge_pkg::M_SPOLL)
		begin
			if (s.bidx == 3'h0)
			begin
				out_b[srq_bridge_pkg::ST_X]   = s.x;
				out_b[srq_bridge_pkg::ST_Q]   = s.q;
				out_b[srq_bridge_pkg::ST_RQS] = s.srq;
			end
			else
			begin
				out_b = lam_b[s.bidx[1:0] - 2'h1];
			end
			out_l = s.bidx == srq_bridge_pkg::POLL_LAST;
			out_e = out_l;
		end
		else if (s.bm != srq_bridge_pkg::B_NORM && !s.q)
		begin
			if (s.bidx == 3'h0)
			begin
				out_b = {6'h00, s.q, s.x};
			end
			else
			begin
				out_l = 1'b1;
				out_e = 1'b1;
			end
		end
		else if (s.bidx < {1'b0, s.nb})
		begin
			out_b = s.rd[8*s.bidx[1:0] +: 8];
			out_l = s.bm != srq_bridge_pkg::B_NORM && s.bidx == {1'b0, s.nb} - 3'h1;
		end
		else
		begin
			out_b = {6'h00, s.q, s.x};
			out_l = 1'b1;
			out_e = 1'b1;
		end
	end

	// ==========================================================
	// next state
	always_comb
	begin
		next_s         = s;
		next_s.pready  = psel && !penable;
		if (psel && !penable)
		begin
			next_s.pslverr = 1'b0;
			next_s.prdata  = 32'h0000_0000;
			unique case (paddr)
				srq_bridge_pkg::OFS_CTRL:
					next_s.prdata = 32'h0000_0000;
				srq_bridge_pkg::OFS_STATUS:
					next_s.prdata = {14'h0000, s.bm, s.nb, s.pc, s.pz, s.inh, s.en,
						s.q, s.x, s.srq, s.busy, s.ph, s.mode};
				srq_bridge_pkg::OFS_FIELDS:
					next_s.prdata = {18'h00000, s.cmd.f, s.cmd.a, s.cmd.n};
				srq_bridge_pkg::OFS_WDATA:
					next_s.prdata = {8'h00, s.cmd.w};
				default:
					next_s.pslverr = 1'b1;
			endcase
		end

		// gpib interface commands
		if (cmd_valid)
		begin
			unique case (cmd_code)
				srq_bridge_pkg::G_IFC:
					next_s.mode = srq_bridge_pkg::M_IDLE;
				srq_bridge_pkg::G_SPE:
				begin
					next_s.mode = srq_bridge_pkg::M_SPOLL;
					next_s.ph   = srq_bridge_pkg::P_IDLE;
				end
				srq_bridge_pkg::G_SPD:
				begin
					if (s.mode == srq_bridge_pkg::M_SPOLL)
					begin
						next_s.mode     = srq_bridge_pkg::M_IDLE;
						next_s.ph       = srq_bridge_pkg::P_IDLE;
						next_s.tk.valid = 1'b0;
					end
					next_s.srq = 1'b0;
				end
				srq_bridge_pkg::G_MTA:
				begin
					next_s.bidx = 3'h0;
					if (s.mode == srq_bridge_pkg::M_SPOLL)
					begin
						next_s.ph = srq_bridge_pkg::P_SEND;
					end
					else
					begin
						next_s.mode = srq_bridge_pkg::M_TALK;
						next_s.ph   = srq_bridge_pkg::P_WAIT;
						next_s.cnt  = 11'h000;
					end
				end
				srq_bridge_pkg::G_MLA:
				begin
					next_s.mode  = srq_bridge_pkg::M_LISTEN;
					next_s.ph    = srq_bridge_pkg::P_IDLE;
					next_s.busy  = 1'b0;
					next_s.c     = 1'b0;
					next_s.z     = 1'b0;
					next_s.first = 1'b1;
					next_s.seq   = 3'h0;
				end
				srq_bridge_pkg::G_UNL:
					if (s.mode == srq_bridge_pkg::M_LISTEN)
						next_s.mode = srq_bridge_pkg::M_IDLE;
				srq_bridge_pkg::G_UNT:
					if (s.mode == srq_bridge_pkg::M_TALK)
					begin
						next_s.mode     = srq_bridge_pkg::M_IDLE;
						next_s.ph       = srq_bridge_pkg::P_IDLE;
						next_s.busy     = 1'b0;
						next_s.c        = 1'b0;
						next_s.z        = 1'b0;
						next_s.tk.valid = 1'b0;
					end
				default:
					next_s.mode = s.mode;
			endcase
		end

		// listener bytes
		if (lbyte_valid && s.mode == srq_bridge_pkg::M_LISTEN)
		begin
			next_s.first = 1'b0;
			if (s.first)
			begin
				if (lbyte < srq_bridge_pkg::FUNC_LIMIT)
				begin
					next_s.cmd.f = lbyte[4:0];
					next_s.seq   = 3'h1;
				end
				else if ((lbyte & srq_bridge_pkg::GRP_MASK) == srq_bridge_pkg::SRQ_BASE)
				begin
					next_s.en  = lbyte[2:0];
					next_s.inh = 1'b0;
				end
				else if (lbyte == srq_bridge_pkg::INH_ON)
				begin
					next_s.inh = 1'b1;
				end
				else if ((lbyte & srq_bridge_pkg::CZ_MASK) == srq_bridge_pkg::CZ_BASE)
				begin
					next_s.pz = s.pz || lbyte[0];
					next_s.pc = s.pc || lbyte[1];
				end
				else if (lbyte[2:0] == 3'h1 || lbyte[2:0] == 3'h2 || lbyte[2:0] == 3'h4)
				begin
					next_s.nb = lbyte[2] ? 2'h3 : lbyte[1] ? 2'h2 : 2'h1;
					if ((lbyte & srq_bridge_pkg::GRP_MASK) == srq_bridge_pkg::NORM_BASE)
						next_s.bm = srq_bridge_pkg::B_NORM;
					else if ((lbyte & srq_bridge_pkg::GRP_MASK) == srq_bridge_pkg::SLOW_BASE)
						next_s.bm = srq_bridge_pkg::B_SLOW;
					else if ((lbyte & srq_bridge_pkg::GRP_MASK) == srq_bridge_pkg::FAST_BASE)
						next_s.bm = srq_bridge_pkg::B_FAST;
					else
						next_s.nb = s.nb;
				end
			end
			else if (s.seq != 3'h0)
			begin
				// unsent fields keep their values
				next_s.seq = s.seq == 3'h5 ? 3'h0 : s.seq + 3'h1;
				unique case (s.seq)
					3'h1: next_s.cmd.a = lbyte[3:0];
					3'h2: next_s.cmd.n = lbyte[4:0];
					3'h3: next_s.cmd.w[7:0] = lbyte;
					3'h4: next_s.cmd.w[15:8] = lbyte;
					3'h5: next_s.cmd.w[23:16] = lbyte;
					default: next_s.seq = 3'h0;
				endcase
			end
		end

		// dataway cycle
		unique case (s.ph)
			srq_bridge_pkg::P_IDLE:
				next_s.ph = next_s.ph;
			srq_bridge_pkg::P_WAIT:
				if (s.cnt != 11'h000)
					next_s.cnt = s.cnt - 11'h001;
				else if (!s.srq)
				begin
					next_s.ph   = srq_bridge_pkg::P_CYC;
					next_s.busy = 1'b1;
					next_s.cnt  = srq_bridge_pkg::CYC_LAST;
					next_s.c    = s.pc;
					next_s.z    = s.pz;
					next_s.pc   = 1'b0;
					next_s.pz   = 1'b0;
				end
			srq_bridge_pkg::P_CYC:
				if (cyc_end)
				begin
					next_s.ph   = srq_bridge_pkg::P_SEND;
					next_s.busy = 1'b0;
					next_s.c    = 1'b0;
					next_s.z    = 1'b0;
					next_s.rd   = dw_r;
					next_s.q    = dw_q;
					next_s.x    = dw_x;
					next_s.bidx = 3'h0;
				end
				else
					next_s.cnt = s.cnt - 11'h001;
			srq_bridge_pkg::P_SEND:
				if (!s.tk.valid)
				begin
					next_s.tk   = '{valid: 1'b1, eoi: out_e, data: out_b};
					next_s.last = out_l;
				end
				else if (take)
				begin
					next_s.tk.valid = 1'b0;
					if (s.mode == srq_bridge_pkg::M_SPOLL && s.bidx == 3'h0)
						next_s.srq = 1'b0;
					if (!s.last)
						next_s.bidx = s.bidx + 3'h1;
					else if (s.mode == srq_bridge_pkg::M_TALK
						&& s.bm != srq_bridge_pkg::B_NORM && s.q)
					begin
						next_s.ph  = srq_bridge_pkg::P_WAIT;
						next_s.cnt = s.bm == srq_bridge_pkg::B_SLOW
							? srq_bridge_pkg::GAP_LAST : 11'h000;
					end
					else
					begin
						next_s.ph = srq_bridge_pkg::P_IDLE;
						if (s.mode == srq_bridge_pkg::M_TALK)
							next_s.bm = srq_bridge_pkg::B_NORM;
					end
				end
			default:
				next_s.ph = srq_bridge_pkg::P_IDLE;
		endcase

		// service request: set wins over poll clears, interface clear wins over set
		if (lam_ev || (cyc_end && ((s.en[1] && !dw_q) || (s.en[2] && !dw_x))))
			next_s.srq = 1'b1;

		// interface clear keeps loaded fields
		if (do_clr)
		begin
			next_s.mode = srq_bridge_pkg::M_IDLE;
			next_s.ph   = srq_bridge_pkg::P_IDLE;
			next_s.bm   = srq_bridge_pkg::B_NORM;
			next_s.tk   = '0;
			next_s.en   = srq_bridge_pkg::RST_EN;
			next_s.nb   = srq_bridge_pkg::RST_NB;
			next_s.inh  = 1'b0;
			next_s.pc   = 1'b0;
			next_s.pz   = 1'b0;
			next_s.srq  = 1'b0;
			next_s.busy = 1'b0;
			next_s.c    = 1'b0;
			next_s.z    = 1'b0;
			next_s.seq  = 3'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s      <= '0;
			s.mode <= srq_bridge_pkg::M_IDLE;
			s.ph   <= srq_bridge_pkg::P_IDLE;
			s.bm   <= srq_bridge_pkg::B_NORM;
			s.en   <= srq_bridge_pkg::RST_EN;
			s.nb   <= srq_bridge_pkg::RST_NB;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign prdata  = s.prdata;
	assign pready  = s.pready;
	assign pslverr = s.pslverr;
	assign tk      = s.tk;
	assign srq     = s.srq;
	assign dw_cmd  = s.cmd;
	assign dw_busy = s.busy;
	assign dw_c    = s.c;
	assign dw_z    = s.z;
	assign dw_i    = s.inh;

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence setup_srq_s;
		setup_hit;
	endsequence
	sequence cyc_start_s;
		$rose(dw_busy);
	endsequence
	sequence status_taken_s;
		take && s.mode == srq_bridge_pkg::M_SPOLL && s.bidx == 3'h0;
	endsequence

	srq_enable_set_a: assert property (setup_srq_s ##0 !do_clr
		|=> dw_i == 1'b0 && s.en == $past(lbyte[2:0]))
		else $error("setup byte did not load enables or release inhibit");
	lam_srq_a: assert property (lam_ev && !do_clr |=> srq)
		else $error("enabled lam did not raise service request");
	no_cycle_srq_a: assert property (cyc_start_s |-> !$past(srq))
		else $error("dataway cycle started with request pending");
	cycle_length_a: assert property (cyc_start_s |-> s.cnt == srq_bridge_pkg::CYC_LAST
		&& s.ph == srq_bridge_pkg::P_CYC)
		else $error("dataway cycle length wrong");
	cycle_count_a: assert property (dw_busy && s.cnt != 11'h000 && !do_clr && !cmd_valid
		|=> dw_busy && s.cnt == $past(s.cnt) - 11'h001)
		else $error("dataway cycle count did not step");
	cycle_end_a: assert property (cyc_end |=> !dw_busy)
		else $error("dataway cycle did not end");
	status_clear_a: assert property (status_taken_s ##0 (!lam_ev && !cyc_end)
		|=> !srq)
		else $error("request not withdrawn after status byte");
	clear_first_a: assert property ((dw_c || dw_z) |-> dw_busy)
		else $error("clear or initialize outside a cycle");
	cz_once_a: assert property (cyc_start_s |-> !s.pc && !s.pz)
		else $error("clear or initialize still pending after cycle start");
	inhibit_hold_a: assert property (dw_i && !do_clr && !setup_hit
		|=> dw_i)
		else $error("inhibit dropped without release command");
	status_bits_a: assert property (s.ph == srq_bridge_pkg::P_SEND && !s.tk.valid
		&& s.mode == srq_bridge_pkg::M_SPOLL && s.bidx == 3'h0 && !cmd_valid && !do_clr
		|=> tk.valid && tk.data[srq_bridge_pkg::ST_RQS] == $past(srq)
		&& tk.data[srq_bridge_pkg::ST_Q] == s.q)
		else $error("status byte bits wrong");
	block_end_a: assert property (take && s.mode == srq_bridge_pkg::M_TALK
		&& s.bm != srq_bridge_pkg::B_NORM && s.last && !do_clr && !cmd_valid
		|=> s.bm == srq_bridge_pkg::B_NORM || s.ph == srq_bridge_pkg::P_WAIT)
		else $error("block transfer end did not revert mode");
endmodule : srq_bridge
`default_nettype wire

// ==== logic/srq_bridge_pkg.sv ====
// Functional notes
// - raise service request on LAM, Q equal zero or X equal zero, each enabled
// - setup bytes 64 to 71 load the three request enables from low bits
// - every request-enable setup byte also releases crate inhibit
// - poll answer is status byte then LAM bytes; X, Q and service flag
// - status service flag is one only when this unit raised the request
// - four LAM bytes, six slots each except five in the last, slot one in the least significant bit
// - request is withdrawn once the controller takes the status byte
// - a LAM still present and enabled raises the request again at once
// - no dataway cycle starts while our own request is pending
// - clear and initialize are driven only during the next dataway cycle
// - inhibit stays asserted over any number of cycles until released
// - byte 64 releases inhibit and also clears every request enable
// - function code first, then subaddress, station, up to three data bytes
// - loaded function, subaddress, station and data are kept until rewritten
// - loading may stop after any byte; fields not resent keep old values
// - talk addressing runs one dataway cycle with the stored fields, or repeated cycles in block mode
// - a read returns the data bytes then one response byte
// - block read ending on Q zero sends response byte then zero with EOI
// - bytes 105 and 106 select fast block reads of 8 and 16 bits
// - in block mode cycles repeat with the same fields until data ends
// - poll disable returns to idle and clears the pending request
// - talk address in poll mode sends status, otherwise runs a cycle
// - after a block transfer the mode returns to normal, same width
package srq_bridge_pkg;
	typedef enum logic [1:0] {M_IDLE = 2'b00, M_LISTEN = 2'b01, M_TALK = 2'b10,
		M_SPOLL = 2'b11} mode_t;
	typedef enum logic [1:0] {P_IDLE = 2'b00, P_WAIT = 2'b01, P_CYC = 2'b10,
		P_SEND = 2'b11} phase_t;
	typedef enum logic [2:0] {G_IFC = 3'b000, G_SPE = 3'b001, G_SPD = 3'b010,
		G_MTA = 3'b011, G_MLA = 3'b100, G_UNL = 3'b101, G_UNT = 3'b110} gcmd_t;
	typedef enum logic [1:0] {B_NORM = 2'b00, B_SLOW = 2'b01, B_FAST = 2'b10} bmode_t;
	typedef struct packed {
		logic [4:0]  f;
		logic [3:0]  a;
		logic [4:0]  n;
		logic [23:0] w;
	} dw_cmd_t;
	typedef struct packed {
		logic       valid;
		logic       eoi;
		logic [7:0] data;
	} talk_t;
	// timing
	localparam int          CLK_NS   = 25;
	localparam int          CYC_NS   = 1000;
	localparam int          GAP_NS   = 35000;
	localparam int          CYC_CLKS = (CYC_NS + CLK_NS - 1) / CLK_NS;
	localparam int          GAP_CLKS = (GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [10:0] CYC_LAST = 11'(CYC_CLKS - 1);
	localparam logic [10:0] GAP_LAST = 11'(GAP_CLKS - 1);
	// setup byte codes
	localparam logic [7:0] FUNC_LIMIT = 8'h20;
	localparam logic [7:0] GRP_MASK   = 8'hF8;
	localparam logic [7:0] SRQ_BASE   = 8'h40;
	localparam logic [7:0] INH_ON     = 8'h48;
	localparam logic [7:0] CZ_MASK    = 8'hFC;
	localparam logic [7:0] CZ_BASE    = 8'h20;
	localparam logic [7:0] NORM_BASE  = 8'h60;
	localparam logic [7:0] SLOW_BASE  = 8'h78;
	localparam logic [7:0] FAST_BASE  = 8'h68;
	// status byte bits
	localparam int ST_X   = 0;
	localparam int ST_Q   = 1;
	localparam int ST_RQS = 6;
	localparam logic [2:0] POLL_LAST = 3'h4;
	// register map
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_FIELDS = 8'h08;
	localparam logic [7:0] OFS_WDATA  = 8'h0C;
	// reset values
	localparam logic [2:0] RST_EN = 3'h0;
	localparam logic [1:0] RST_NB = 2'h1;
endpackage : srq_bridge_pkg

// ==== dv/gpib_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// controller on the far side of the gpib link
module gpib_ctl_model
(
	input  wire logic                  pclk,
	output logic                       cmd_valid,
	output logic [2:0]                 cmd_code,
	output logic                       lbyte_valid,
	output logic [7:0]                 lbyte,
	output logic                       tk_ready,
	input  wire srq_bridge_pkg::talk_t tk
);
	logic       slow;
	logic [8:0] got[$];

	initial
	begin
		slow        = 1'b0;
		cmd_valid   = 1'b0;
		cmd_code    = 3'h7;
		lbyte_valid = 1'b0;
		lbyte       = 8'h00;
		tk_ready    = 1'b0;
	end

	// ==========================================
	// talker bytes taken, stalling when slow
	always @(posedge pclk)
	begin
		tk_ready <= slow ? ~tk_ready : 1'b1;
		if (tk.valid && tk_ready)
			got.push_back({tk.eoi, tk.data});
	end

	// ==========================================
	// interface commands, code inverted when idle
	task automatic send_cmd(input logic [2:0] c);
		@(posedge pclk);
		cmd_valid <= 1'b1;
		cmd_code  <= c;
		@(posedge pclk);
		cmd_valid <= 1'b0;
		cmd_code  <= ~c;
	endtask : send_cmd

	// listener bytes, any count may be sent
	task automatic send_byte(input logic [7:0] b);
		@(posedge pclk);
		lbyte_valid <= 1'b1;
		lbyte       <= b;
		@(posedge pclk);
		lbyte_valid <= 1'b0;
		lbyte       <= ~b;
	endtask : send_byte
endmodule : gpib_ctl_model
`default_nettype wire

// ==== dv/gpib_camac_srq_command_bridge_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpib_camac_srq_command_bridge_tb;
	typedef struct {logic [7:0] b; logic [9:0] st;} row_t;
	logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]              paddr;
	logic [31:0]             pwdata, prdata, rd;
	logic                    cmd_valid, lbyte_valid, tk_ready, srq, err;
	logic [2:0]              cmd_code;
	logic [7:0]              lbyte;
	srq_bridge_pkg::talk_t   tk;
	srq_bridge_pkg::dw_cmd_t dw_cmd;
	logic                    dw_busy, dw_c, dw_z, dw_i, dw_q, dw_x, busy_d;
	logic [23:0]             dw_r;
	logic [22:0]             lam;
	logic [1:0]              cz_seen;
	logic [8:0]              exp_q[$];
	int                      fail_count, checks_done, cycles, blk_left, c0;
	row_t rows[16] = '{'{8'h48, 10'h048}, '{8'h47, 10'h047}, '{8'h48, 10'h04F},
		'{8'h40, 10'h040}, '{8'h41, 10'h041}, '{8'h42, 10'h042}, '{8'h43, 10'h043},
		'{8'h44, 10'h044}, '{8'h45, 10'h045}, '{8'h46, 10'h046}, '{8'h23, 10'h076},
		'{8'h61, 10'h076}, '{8'h6A, 10'h2B6}, '{8'h7C, 10'h1F6}, '{8'h69, 10'h276},
		'{8'h62, 10'h0B6}};

	srq_bridge i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.lbyte_valid(lbyte_valid), .lbyte(lbyte), .tk_ready(tk_ready), .tk(tk),
		.srq(srq), .dw_cmd(dw_cmd), .dw_busy(dw_busy), .dw_c(dw_c), .dw_z(dw_z),
		.dw_i(dw_i), .dw_r(dw_r), .dw_q(dw_q), .dw_x(dw_x), .lam(lam));
	gpib_ctl_model i_ctl (.pclk(pclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.lbyte_valid(lbyte_valid), .lbyte(lbyte), .tk_ready(tk_ready), .tk(tk));

	// ==========================================
	// clock, watchdog, dataway module
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial
	begin
		repeat (100000) @(posedge pclk);
		fail_count++;
		wrap_up();
	end
	always @(posedge pclk)
	begin
		busy_d <= dw_busy;
		if (dw_busy)
			cz_seen <= cz_seen | {dw_c, dw_z};
		if (busy_d && !dw_busy)
		begin
			cycles <= cycles + 1;
			if (blk_left > 0)
			begin
				blk_left <= blk_left - 1;
				dw_r     <= dw_r + 24'h000001;
				dw_q     <= (blk_left > 1);
			end
		end
	end

	// ==========================================
	// tasks
	task automatic wrap_up;
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k == 50)
		begin
			fail_count++;
			wrap_up();
		end
	endtask : apb

	task automatic listen(input logic [7:0] b[$]);
		i_ctl.send_cmd(srq_bridge_pkg::G_MLA);
		foreach (b[i])
			i_ctl.send_byte(b[i]);
		i_ctl.send_cmd(srq_bridge_pkg::G_UNL);
	endtask : listen

	task automatic talk(input logic [2:0] c);
		int k;
		i_ctl.send_cmd(c);
		for (k = 0; k < 5000 && i_ctl.got.size() < exp_q.size(); k++)
			@(posedge pclk);
		if (k == 5000)
		begin
			fail_count++;
			wrap_up();
		end
		while (exp_q.size() > 0)
			check(32'(i_ctl.got.pop_front()), 32'(exp_q.pop_front()));
		i_ctl.send_cmd(c == srq_bridge_pkg::G_MTA ? srq_bridge_pkg::G_UNT : 3'h7);
	endtask : talk

	task automatic wait_srq(input logic v);
		int k;
		for (k = 0; k < 200 && srq !== v; k++)
			@(posedge pclk);
		check(32'(srq), 32'(v));
	endtask : wait_srq

	// ==========================================
	// main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{dw_r, dw_q, dw_x, lam, cz_seen, busy_d} = '0;
		{fail_count, checks_done, cycles, blk_left} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, srq_bridge_pkg::OFS_STATUS, 32'h0);
		check(rd, 32'h0000_4000);
		check(32'({srq, dw_i, tk.valid}), 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		check(32'(err), 32'h1);
		foreach (rows[i])
		begin
			listen('{rows[i].b});
			apb(1'b0, srq_bridge_pkg::OFS_STATUS, 32'h0);
			check(32'(rd[17:8]), 32'(rows[i].st));
		end
		listen('{8'h48});
		listen('{8'h10, 8'h05, 8'h03, 8'hAA, 8'hBB, 8'hCC});
		check(32'(dw_cmd), 32'({5'h10, 4'h5, 5'h03, 24'hCCBBAA}));
		apb(1'b0, srq_bridge_pkg::OFS_FIELDS, 32'h0);
		check(rd, 32'({5'h10, 4'h5, 5'h03}));
		{dw_r, dw_q, dw_x} <= {24'hC3B2A1, 2'b11};
		exp_q = '{9'h0A1, 9'h0B2, 9'h103};
		talk(srq_bridge_pkg::G_MTA);
		check(32'(cz_seen), 32'h3);
		cz_seen <= 2'b00;
		exp_q = '{9'h0A1, 9'h0B2, 9'h103};
		talk(srq_bridge_pkg::G_MTA);
		check(32'({cz_seen, dw_i, 5'(cycles)}), 32'({2'b00, 1'b1, 5'h2}));
		listen('{8'h1A});
		check(32'(dw_cmd), 32'({5'h1A, 4'h5, 5'h03, 24'hCCBBAA}));
		listen('{8'h42});
		check(32'(dw_i), 32'h0);
		dw_q <= 1'b0;
		exp_q = '{9'h0A1, 9'h0B2, 9'h101};
		talk(srq_bridge_pkg::G_MTA);
		wait_srq(1'b1);
		c0 = cycles;
		i_ctl.send_cmd(srq_bridge_pkg::G_MTA);
		repeat (100) @(posedge pclk);
		check(32'(cycles - c0), 32'h0);
		i_ctl.send_cmd(srq_bridge_pkg::G_UNT);
		i_ctl.send_cmd(srq_bridge_pkg::G_SPE);
		exp_q = '{9'h041, 9'h000, 9'h000, 9'h000, 9'h100};
		talk(srq_bridge_pkg::G_MTA);
		wait_srq(1'b0);
		i_ctl.send_cmd(srq_bridge_pkg::G_SPD);
		lam <= {5'h16, 6'h19, 6'h25, 6'h2B};
		listen('{8'h41});
		wait_srq(1'b1);
		i_ctl.send_cmd(srq_bridge_pkg::G_SPE);
		exp_q = '{9'h041, 9'h02B, 9'h025, 9'h019, 9'h116};
		talk(srq_bridge_pkg::G_MTA);
		check(32'(srq), 32'h1);
		lam <= 23'h0;
		i_ctl.send_cmd(srq_bridge_pkg::G_SPD);
		wait_srq(1'b0);
		apb(1'b0, srq_bridge_pkg::OFS_STATUS, 32'h0);
		check(32'(rd[1:0]), 32'h0);
		listen('{8'h69});
		{dw_r, dw_q, dw_x, blk_left} <= {24'h000011, 2'b11, 32'd2};
		i_ctl.slow = 1'b1;
		c0 = cycles;
		exp_q = '{9'h011, 9'h012, 9'h001, 9'h100};
		talk(srq_bridge_pkg::G_MTA);
		check(32'(cycles - c0), 32'h3);
		apb(1'b0, srq_bridge_pkg::OFS_STATUS, 32'h0);
		check(32'(rd[17:14]), 32'h1);
		apb(1'b1, srq_bridge_pkg::OFS_CTRL, 32'h1);
		apb(1'b0, srq_bridge_pkg::OFS_STATUS, 32'h0);
		check(32'(rd[13:8]), 32'h0);
		apb(1'b0, srq_bridge_pkg::OFS_FIELDS, 32'h0);
		check(rd, 32'({5'h1A, 4'h5, 5'h03}));
		wrap_up();
	end
endmodule : gpib_camac_srq_command_bridge_tb
`default_nettype wire
